// [include/wdr_pkg.sv]
// Purpose: constants, types and helpers of the watchdog and reset block
// Assumes: 25 MHz system clock, AHB-Lite word registers
// Notes:   timing counts derive from times held in their own unit
package wdr_pkg;

   localparam longint unsigned CLK_HZ = 25_000_000;
   localparam longint unsigned NS_PER_S = 1_000_000_000;

   // register byte addresses
   localparam logic [7:0] ADDR_WATCHDOG_CTRL = 8'h00;
   localparam logic [7:0] ADDR_VSEL = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   localparam logic [27:0] ADDR_HI_ZERO = 28'h0000000;

   // watchdog_ctrl layout
   localparam int KEY_MSB = 7;
   localparam int KEY_LSB = 3;
   localparam int TSEL_MSB = 2;
   localparam logic [4:0] KEY_DISABLE = 5'h15;
   localparam logic [4:0] KEY_ENABLE = 5'h0A;
   localparam logic [7:0] WATCHDOG_CTRL_POR = 8'h53;

   // voltage_select_field codes
   localparam logic [7:0] VSEL_2V10 = 8'h55;
   localparam logic [7:0] VSEL_2V55 = 8'h33;
   localparam logic [7:0] VSEL_3V15 = 8'h99;
   localparam logic [7:0] VSEL_3V80 = 8'hAA;
   localparam logic [7:0] VSEL_POR = VSEL_2V10;

   // system_control_flags and status bit positions
   localparam int CTRL_KEEP_BIT = 7;
   localparam int CTRL_LOW_VOLTAGE_RESET_FLAG_BIT = 2;
   localparam int CTRL_LRF_BIT = 1;
   localparam int CTRL_WRF_BIT = 0;
   localparam int STAT_TO_BIT = 0;

   // watchdog counter and corruption delay
   localparam int WDT_CNT_W = 18;
   localparam logic [1:0] CORRUPT_TICKS = 2'h2;

   // timing, times in ns
   localparam longint unsigned POR_DELAY_NS = 50_000_000;
   localparam longint unsigned RESTART_DELAY_NS = 16_700_000;
   localparam longint unsigned LV_QUAL_NS = 100_000;
   localparam longint unsigned POR_CYC_DEF = POR_DELAY_NS * CLK_HZ / NS_PER_S;
   localparam longint unsigned RST_CYC_DEF =
      RESTART_DELAY_NS * CLK_HZ / NS_PER_S;
   localparam longint unsigned LVQ_CYC_DEF =
      (LV_QUAL_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
   localparam int DLY_W = 21;

   // values handed to the core and port logic during reset
   localparam logic [11:0] PC_RESET_VAL = 12'h000;
   localparam logic [7:0] PORT_RESET_VAL = 8'hFF;

   // AHB-Lite
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      ST_POR  = 2'h0,
      ST_RUN  = 2'h1,
      ST_HOLD = 2'h3,
      ST_WAIT = 2'h2
   } wdr_state_t;

   // terminal count for the selected division ratio
   function automatic logic [WDT_CNT_W-1:0] wdt_limit(input logic [2:0] ts);
      logic [4:0] sh;
      case (ts)
         3'h0: sh = 5'h08;
         3'h1: sh = 5'h0A;
         3'h2: sh = 5'h0C;
         3'h3: sh = 5'h0E;
         3'h4: sh = 5'h0F;
         3'h5: sh = 5'h10;
         3'h6: sh = 5'h11;
         default: sh = 5'h12;
      endcase
      wdt_limit = (18'h00001 << sh) - 18'h00001;
   endfunction

   function automatic logic vsel_valid(input logic [7:0] v);
      vsel_valid = (v == VSEL_2V10) || (v == VSEL_2V55) ||
                   (v == VSEL_3V15) || (v == VSEL_3V80);
   endfunction

endpackage

// [core/wdr_sync.sv]
// Purpose: reset release and low-speed oscillator tick for the block
// Assumes: LOW_SPEED_INTERNAL_OSC pin is synchronous to the system clock
// Notes:   tick is one system cycle per rising oscillator edge
`timescale 1ns/1ps
module wdr_sync
   import wdr_pkg::*;
(
   // clock and raw reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // oscillator
   input  wire logic low_speed_internal_osc_in,
   // results
   output wire logic rst_n_out,
   output wire logic tick_out
);

   typedef struct packed {
      logic r1;
      logic r2;
      logic prev;
   } wdr_sync_t;

   wdr_sync_t q;
   wdr_sync_t n;

   always_comb begin
      n = q;
      n.r1 = 1'b1;
      n.r2 = q.r1;
      n.prev = low_speed_internal_osc_in;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign rst_n_out = q.r2;
   // counts only oscillator edges, never system cycles
   assign tick_out = low_speed_internal_osc_in & ~q.prev;

endmodule // wdr_sync

// [core/wdr_top.sv]
// Purpose: watchdog timer with keyed control and device reset generation
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   system reset out stays low until the power-on delay has run
//
// Behaviour
// - watchdog overflow issues full device reset; the code only sets the flag and clears PC/SP when it comes in power-down
// - key 10101 disables, 01010 enables, else reset
// - normal timeout resets device, sets timeout flag
// - sleep timeout sets flag, clears PC/SP only
// - bad key, clear instruction, halt clear counter
// - only clear instruction clears among instructions; the code also clears the counter on halt
// - division ratios from two^8 to two^18
// - power-on loads zero program counter
// - ports and directions start all ones
// - hold execution for power-on delay
// - undervoltage must persist before reset fires
// - bad select code resets after 2-3 ticks
// - only four select codes are valid
// - undervoltage reset keeps select register
// - bad select reset restores select default
// - select register powers up as 0x55
// - power-down disables undervoltage reset
// - undervoltage flag bit 2, write-zero clear
// - select corruption flag bit 1, write-zero clear
// - control bits six to three read zero
// - timeout reset like undervoltage, 16.7 ms
// - bad key resets after 2-3 ticks, bit 0
// - three-bit select picks division ratio
// - counter clocked by low-speed oscillator only
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module wdr_top
   import wdr_pkg::*;
#(
   parameter int unsigned POR_CYCLES     = int'(POR_CYC_DEF),
   parameter int unsigned RESTART_CYCLES = int'(RST_CYC_DEF),
   parameter int unsigned LV_QUAL_CYCLES = int'(LVQ_CYC_DEF)
)(
   // clock and reset
   input  wire logic        CLK_SYS_IN,
   input  wire logic        RST_N_IN,
   // AHB-Lite slave
   input  wire logic        HSEL_IN,
   input  wire logic [31:0] HADDR_IN,
   input  wire logic [1:0]  HTRANS_IN,
   input  wire logic        HWRITE_IN,
   input  wire logic [2:0]  HSIZE_IN,
   input  wire logic [31:0] HWDATA_IN,
   input  wire logic        HREADY_IN,
   output wire logic [31:0] HRDATA_OUT,
   output wire logic        HREADYOUT_OUT,
   output wire logic        HRESP_OUT,
   // core events
   input  wire logic        WATCHDOG_CLEAR_INSTRUCTION_IN,
   input  wire logic        HALT_IN,
   input  wire logic        POWER_DOWN_IN,
   // analog side
   input  wire logic        LOW_SPEED_INTERNAL_OSC_IN,
   input  wire logic        UNDERVOLT_IN,
   output wire logic [7:0]  VSEL_OUT,
   // reset results
   output wire logic        SYS_RST_N_OUT,
   output wire logic        PC_SP_CLR_OUT,
   output wire logic        TIMEOUT_FLAG_OUT,
   output wire logic        IDLE_SYSCLK_KEEP_OUT,
   output wire logic [11:0] PC_INIT_OUT,
   output wire logic [7:0]  PORT_INIT_OUT
);

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      wdr_state_t             st;
      logic [7:0]             watchdog_ctrl;
      logic [7:0]             vsel;
      logic                   keep;
      logic                   low_voltage_reset_flag;
      logic                   select_corruption_flag;
      logic                   watchdog_key_corruption_flag;
      logic                   to;
      logic [WDT_CNT_W-1:0]   wcnt;
      logic [1:0]             kpend;
      logic [1:0]             spend;
      logic [DLY_W-1:0]       dcnt;
      logic [DLY_W-1:0]       lvcnt;
      logic                   sel_cause;
      logic                   pcsp;
      logic                   rstn;
      logic                   a_act;
      logic                   a_wr;
      logic [7:0]             a_addr;
      logic [31:0]            rdata;
   } wdr_top_t;

   localparam wdr_top_t RESET_STATE = '{
      st: ST_POR, watchdog_ctrl: WATCHDOG_CTRL_POR, vsel: VSEL_POR,
      keep: 1'b0, low_voltage_reset_flag: 1'b0, select_corruption_flag: 1'b0, watchdog_key_corruption_flag: 1'b0, to: 1'b0,
      wcnt: '0, kpend: 2'h0, spend: 2'h0, dcnt: '0, lvcnt: '0,
      sel_cause: 1'b0, pcsp: 1'b0, rstn: 1'b0, a_act: 1'b0,
      a_wr: 1'b0, a_addr: 8'h00, rdata: 32'h00000000};

   localparam logic [DLY_W-1:0] POR_LAST = DLY_W'(POR_CYCLES - 1);
   localparam logic [DLY_W-1:0] RESTART_LAST = DLY_W'(RESTART_CYCLES - 1);
   localparam logic [DLY_W-1:0] LVQ_LAST = DLY_W'(LV_QUAL_CYCLES);

   wdr_top_t q;
   wdr_top_t n;
   logic     rst_n;
   logic     tick;
   logic     key_en;
   logic     key_bad;
   logic     sel_bad;
   logic     ovf;
   logic     key_fire;
   logic     sel_fire;
   logic     lv_cond;
   logic     lv_fire;
   logic     addr_ok;
   logic     go;

   wdr_sync u_sync (
      .clk_in    (CLK_SYS_IN),
      .rst_n_in  (RST_N_IN),
      .low_speed_internal_osc_in   (LOW_SPEED_INTERNAL_OSC_IN),
      .rst_n_out (rst_n),
      .tick_out  (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      n = q;
      n.pcsp = 1'b0;
      key_en = q.watchdog_ctrl[KEY_MSB:KEY_LSB] == KEY_ENABLE;
      key_bad = !key_en && (q.watchdog_ctrl[KEY_MSB:KEY_LSB] != KEY_DISABLE);
      sel_bad = !vsel_valid(q.vsel);
      // overflow at the selected counter width
      ovf = (q.st == ST_RUN) && key_en && tick &&
            (q.wcnt == wdt_limit(q.watchdog_ctrl[TSEL_MSB:0]));
      key_fire = (q.st == ST_RUN) && key_bad && tick &&
                 (q.kpend == CORRUPT_TICKS);
      sel_fire = (q.st == ST_RUN) && sel_bad && tick &&
                 (q.spend == CORRUPT_TICKS);
      lv_cond = UNDERVOLT_IN && !POWER_DOWN_IN && !sel_bad;
      lv_fire = (q.st == ST_RUN) && lv_cond && (q.lvcnt == LVQ_LAST);

      // data phase write
      if (q.a_act && q.a_wr) begin
         case (q.a_addr)
            ADDR_WATCHDOG_CTRL: n.watchdog_ctrl = HWDATA_IN[7:0];
            ADDR_VSEL: n.vsel = HWDATA_IN[7:0];
            ADDR_CTRL: begin
               n.keep = HWDATA_IN[CTRL_KEEP_BIT];
               // ones are ignored, only zero clears
               if (!HWDATA_IN[CTRL_LOW_VOLTAGE_RESET_FLAG_BIT]) n.low_voltage_reset_flag = 1'b0;
               if (!HWDATA_IN[CTRL_LRF_BIT]) n.select_corruption_flag = 1'b0;
               if (!HWDATA_IN[CTRL_WRF_BIT]) n.watchdog_key_corruption_flag = 1'b0;
            end
            default: n.keep = q.keep;
         endcase
      end

      // watchdog counter, advances on oscillator ticks only
      if (!key_en) begin
         n.wcnt = '0;
      end else if (tick) begin
         n.wcnt = ovf ? '0 : q.wcnt + 1'b1;
      end
      if (WATCHDOG_CLEAR_INSTRUCTION_IN || HALT_IN) begin
         n.wcnt = '0;
         n.to = 1'b0;
      end
      if (ovf) begin
         n.to = 1'b1;
      end

      // corruption tick counters, saturate at the firing count
      if (!key_bad) begin
         n.kpend = 2'h0;
      end else if (tick && q.kpend != CORRUPT_TICKS) begin
         n.kpend = q.kpend + 2'h1;
      end
      if (!sel_bad) begin
         n.spend = 2'h0;
      end else if (tick && q.spend != CORRUPT_TICKS) begin
         n.spend = q.spend + 2'h1;
      end

      // undervoltage qualification; short dips restart the count
      if (!lv_cond) begin
         n.lvcnt = '0;
      end else if (q.lvcnt != LVQ_LAST) begin
         n.lvcnt = q.lvcnt + 1'b1;
      end

      // reset sequencer
      case (q.st)
         ST_POR: begin
            if (q.dcnt == POR_LAST) begin
               n.st = ST_RUN;
               n.dcnt = '0;
            end else begin
               n.dcnt = q.dcnt + 1'b1;
            end
         end
         ST_RUN: begin
            if (key_fire || sel_fire || lv_fire ||
                (ovf && !POWER_DOWN_IN)) begin
               n.st = ST_HOLD;
               if (key_fire) n.watchdog_key_corruption_flag = 1'b1;
               if (sel_fire) n.select_corruption_flag = 1'b1;
               if (lv_fire) n.low_voltage_reset_flag = 1'b1;
               n.sel_cause = sel_fire;
            end else if (ovf) begin
               n.pcsp = 1'b1;
            end
         end
         ST_HOLD: begin
            // watchdog control back to power-on value, select register too after a bad select code
            n.watchdog_ctrl = WATCHDOG_CTRL_POR;
            if (q.sel_cause) begin
               n.vsel = VSEL_POR;
            end else begin
               n.vsel = q.vsel;
            end
            if (tick) begin
               n.st = ST_WAIT;
               n.dcnt = '0;
            end
         end
         ST_WAIT: begin
            if (q.dcnt == RESTART_LAST) begin
               n.st = ST_RUN;
               n.dcnt = '0;
               n.sel_cause = 1'b0;
            end else begin
               n.dcnt = q.dcnt + 1'b1;
            end
         end
         default: n.st = ST_POR;
      endcase
      // watchdog, corruption and undervoltage counters stay clear while the device is held in reset
      if (n.st != ST_RUN) begin
         n.wcnt = '0;
         n.kpend = 2'h0;
         n.spend = 2'h0;
         n.lvcnt = '0;
      end
      n.rstn = n.st == ST_RUN;

      // address phase; read data taken from the updated copy
      addr_ok = HADDR_IN[31:4] == ADDR_HI_ZERO;
      go = HSEL_IN && HREADY_IN && HTRANS_IN[1];
      n.a_act = go && addr_ok;
      n.a_wr = HWRITE_IN;
      n.a_addr = HADDR_IN[7:0];
      n.rdata = 32'h00000000;
      if (go && addr_ok && !HWRITE_IN) begin
         case (HADDR_IN[7:0])
            ADDR_WATCHDOG_CTRL: n.rdata[7:0] = n.watchdog_ctrl;
            ADDR_VSEL: n.rdata[7:0] = n.vsel;
            ADDR_CTRL: n.rdata[7:0] = {n.keep, 4'h0,
                                       n.low_voltage_reset_flag, n.select_corruption_flag, n.watchdog_key_corruption_flag};
            ADDR_STAT: n.rdata[STAT_TO_BIT] = n.to;
            default: n.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         q <= RESET_STATE;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign HRDATA_OUT = q.rdata;
   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT = 1'b0;
   assign VSEL_OUT = q.vsel;
   assign SYS_RST_N_OUT = q.rstn;
   assign PC_SP_CLR_OUT = q.pcsp;
   assign TIMEOUT_FLAG_OUT = q.to;
   assign IDLE_SYSCLK_KEEP_OUT = q.keep;
   // core and ports load these while reset is low
   assign PC_INIT_OUT = PC_RESET_VAL;
   assign PORT_INIT_OUT = PORT_RESET_VAL;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!rst_n);

   sequence s_ovf_awake;
      ovf && !POWER_DOWN_IN;
   endsequence

   // a bad select code in the same tick still takes the full reset
   sequence s_ovf_asleep;
      ovf && POWER_DOWN_IN && !sel_fire;
   endsequence

   chk_normal_timeout: assert property (
      s_ovf_awake |=> (q.st == ST_HOLD) && q.to && !SYS_RST_N_OUT)
      else $error("awake timeout did not reset with flag");

   chk_sleep_timeout: assert property (
      s_ovf_asleep ##1 1'b1 |-> PC_SP_CLR_OUT && q.to &&
                                (q.st == ST_RUN))
      else $error("sleep timeout not pc/sp clear only");

   chk_key_corrupt: assert property (
      key_fire |=> q.watchdog_key_corruption_flag && (q.st == ST_HOLD) && !SYS_RST_N_OUT)
      else $error("bad key did not reset with flag");

   chk_clear_counter: assert property (
      (WATCHDOG_CLEAR_INSTRUCTION_IN || HALT_IN) && !ovf |=> (q.wcnt == '0) && !q.to)
      else $error("clear instruction left counter running");

   chk_select_restore: assert property (
      (q.st == ST_HOLD) && q.sel_cause && tick |=> q.vsel == VSEL_POR)
      else $error("bad select code not restored");

   chk_select_keep: assert property (
      (q.st == ST_HOLD) && !q.sel_cause && !(q.a_act && q.a_wr)
      |=> $stable(q.vsel))
      else $error("select changed across undervoltage reset");

   chk_flag_sticky: assert property (
      q.low_voltage_reset_flag && !(q.a_act && q.a_wr && q.a_addr == ADDR_CTRL)
      |=> q.low_voltage_reset_flag)
      else $error("undervoltage flag lost without write");

   chk_reserved_zero: assert property (
      q.a_act && !q.a_wr && (q.a_addr == ADDR_CTRL)
      |-> HRDATA_OUT[6:3] == 4'h0)
      else $error("reserved control bits read nonzero");

   chk_pd_no_lvr: assert property (
      POWER_DOWN_IN |=> q.lvcnt == '0)
      else $error("undervoltage qualified in power down");

   chk_hold_tick: assert property (
      (q.st == ST_HOLD) && !tick |=> q.st == ST_HOLD)
      else $error("reset hold left before oscillator tick");

   chk_rst_low: assert property (
      (q.st == ST_POR) && (q.dcnt != POR_LAST) |=> !SYS_RST_N_OUT)
      else $error("system reset released early");

endmodule // wdr_top

// [sim/wdr_core_model.sv]
// Purpose: behavioural processor core issuing watchdog clears and halts
// Assumes: the core executes nothing while the device reset is low
// Notes:   every instruction event is a one-cycle pulse
`timescale 1ns/1ps
module wdr_core_model
#(
   parameter int KICK_CYC = 100
)(
   // clock and device reset
   input  wire logic clk_in,
   input  wire logic sys_rst_n_in,
   // requests from the bench
   input  wire logic kick_en_in,
   input  wire logic clr_req_in,
   input  wire logic halt_req_in,
   // instruction events
   output logic      watchdog_clear_instruction_out,
   output logic      halt_out
);
   // events are unknown only before the first edge, under device reset
   int cnt_q = 0;

   // periodic clears model a healthy program loop
   always @(posedge clk_in) begin
      cnt_q <= (kick_en_in && cnt_q < KICK_CYC - 1) ? cnt_q + 1 : 0;
      watchdog_clear_instruction_out <= sys_rst_n_in && (clr_req_in ||
         (kick_en_in && cnt_q == KICK_CYC - 1));
      halt_out <= sys_rst_n_in && halt_req_in;
   end
endmodule // wdr_core_model

// [sim/tb_wdr_top.sv]
// Purpose: self-checking bench of the watchdog and reset block
// Assumes: shortened delay parameters, oscillator of 8 system cycles
// Notes:   registers are reached through an AHB-Lite master task
`timescale 1ns/1ps
module tb_wdr_top;
   import wdr_pkg::*;
   localparam int POR_C = 20;
   localparam int RST_C = 10;
   localparam int LVQ_C = 5;
   logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, low_speed_internal_osc = 0;
   logic        uv = 0, pd = 0, kick = 0, clr_req = 0, halt_req = 0;
   logic [31:0] haddr = '0, hwdata = '0;
   logic [1:0]  htrans = '0;
   logic [2:0]  hsize = HSIZE_WORD;
   wire logic [31:0] hrdata;
   wire logic        hready, hresp, watchdog_clear_instruction, halt, sys_n, pcsp, to_f, keep;
   wire logic [7:0]  vsel, port_i;
   wire logic [11:0] pc_i;
   int          bad_count = 0, total_checks = 0, ticks = 0, lc = 0;
   int          lows = 0, n, t0;
   logic        f;

   always #20 clk = ~clk;
   // slow oscillator, rising edges counted as ticks
   always @(posedge clk) begin
      if (lc == 3) begin
         lc <= 0;
         low_speed_internal_osc <= ~low_speed_internal_osc;
         if (!low_speed_internal_osc) ticks <= ticks + 1;
      end else lc <= lc + 1;
      if (sys_n !== 1'b1) lows <= lows + 1;
   end

   wdr_top #(.POR_CYCLES(POR_C), .RESTART_CYCLES(RST_C),
      .LV_QUAL_CYCLES(LVQ_C)) i_wdr_top (
      .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel),
      .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
      .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .WATCHDOG_CLEAR_INSTRUCTION_IN(watchdog_clear_instruction), .HALT_IN(halt), .POWER_DOWN_IN(pd),
      .LOW_SPEED_INTERNAL_OSC_IN(low_speed_internal_osc), .UNDERVOLT_IN(uv), .VSEL_OUT(vsel),
      .SYS_RST_N_OUT(sys_n), .PC_SP_CLR_OUT(pcsp),
      .TIMEOUT_FLAG_OUT(to_f), .IDLE_SYSCLK_KEEP_OUT(keep),
      .PC_INIT_OUT(pc_i), .PORT_INIT_OUT(port_i));

   wdr_core_model i_wdr_core_model (
      .clk_in(clk), .sys_rst_n_in(sys_n), .kick_en_in(kick),
      .clr_req_in(clr_req), .halt_req_in(halt_req),
      .watchdog_clear_instruction_out(watchdog_clear_instruction), .halt_out(halt));

   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [7:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 8'h00, r);
      chk(nm, {24'h000000, e}, r);
      chk("hresp", 0, hresp);
   endtask

   // wait for the device reset line to reach a level
   task automatic wsys(input logic v, input int lim, output logic fd,
                       output int k);
      fd = 0;
      for (k = 0; k < lim && !fd; k++) begin
         @(posedge clk);
         fd = (sys_n === v);
      end
   endtask

   task automatic pulse_clr;
      clr_req <= 1'b1;
      @(posedge clk);
      clr_req <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_por;
      chk("run_held", 0, sys_n);
      chk("pc_load", 12'h000, pc_i);
      chk("port_load", 8'hFF, port_i);
      chk("vsel_pin", 8'h55, vsel);
      wsys(1'b1, POR_C + 20, f, n);
      chk("por_done", 1, f);
      chk("por_long", 1, n >= POR_C - 3);
      rdc("watchdog_ctrl_por", ADDR_WATCHDOG_CTRL, 8'h53);
      rdc("vsel_por", ADDR_VSEL, 8'h55);
      rdc("ctrl_por", ADDR_CTRL, 8'h00);
      rdc("stat_por", ADDR_STAT, 8'h00);
      rdc("unmapped", 8'h40, 8'h00);
   endtask

   task automatic t_ctrl;
      wr(ADDR_CTRL, 8'hFF);
      rdc("ctrl_ones", ADDR_CTRL, 8'h80);
      chk("keep_pin", 1, keep);
      wr(ADDR_CTRL, 8'h00);
      rdc("ctrl_zero", ADDR_CTRL, 8'h00);
   endtask

   task automatic t_kick;
      wr(ADDR_WATCHDOG_CTRL, 8'h50);
      pulse_clr();
      t0 = lows;
      kick <= 1'b1;
      repeat (4000) @(posedge clk);
      kick <= 1'b0;
      repeat (40) begin
         halt_req <= 1'b1;
         @(posedge clk);
         halt_req <= 1'b0;
         repeat (99) @(posedge clk);
      end
      chk("kicked_alive", 0, lows - t0);
   endtask

   task automatic t_timeout;
      pulse_clr();
      t0 = ticks;
      wsys(1'b0, 2200, f, n);
      chk("wdt_fired", 1, f);
      chk("wdt_ratio", 1, ticks - t0 >= 254 && ticks - t0 <= 258);
      rdc("stat_to", ADDR_STAT, 8'h01);
      chk("to_pin", 1, to_f);
      wsys(1'b1, 60, f, n);
      chk("restart", 1, f && n >= RST_C);
      rdc("watchdog_ctrl_back", ADDR_WATCHDOG_CTRL, 8'h53);
      pulse_clr();
      repeat (3) @(posedge clk);
      rdc("stat_clr", ADDR_STAT, 8'h00);
   endtask

   task automatic t_sleep;
      wr(ADDR_WATCHDOG_CTRL, 8'h50);
      pd <= 1'b1;
      pulse_clr();
      t0 = lows;
      f = 0;
      for (n = 0; n < 2600 && !f; n++) begin
         @(posedge clk);
         f = (pcsp === 1'b1);
      end
      chk("sleep_pcsp", 1, f);
      chk("sleep_alive", 0, lows - t0);
      rdc("sleep_to", ADDR_STAT, 8'h01);
      pd <= 1'b0;
      wr(ADDR_WATCHDOG_CTRL, 8'hA8);
      t0 = lows;
      repeat (2600) @(posedge clk);
      chk("disabled", 0, lows - t0);
      rdc("watchdog_ctrl_off", ADDR_WATCHDOG_CTRL, 8'hA8);
   endtask

   task automatic t_badkey;
      wr(ADDR_WATCHDOG_CTRL, 8'h00);
      wsys(1'b0, 36, f, n);
      chk("key_reset", 1, f);
      rdc("wrf_set", ADDR_CTRL, 8'h01);
      wsys(1'b1, 60, f, n);
      wr(ADDR_CTRL, 8'h01);
      rdc("wrf_keep", ADDR_CTRL, 8'h01);
      wr(ADDR_CTRL, 8'h00);
      rdc("wrf_clr", ADDR_CTRL, 8'h00);
   endtask

   task automatic t_vsel;
      logic [7:0] codes [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
      t0 = lows;
      foreach (codes[i]) begin
         wr(ADDR_VSEL, codes[i]);
         repeat (40) @(posedge clk);
         rdc("vsel_ok", ADDR_VSEL, codes[i]);
      end
      chk("vsel_quiet", 0, lows - t0);
      wr(ADDR_VSEL, 8'h12);
      wsys(1'b0, 36, f, n);
      chk("sel_reset", 1, f);
      rdc("lrf_set", ADDR_CTRL, 8'h02);
      rdc("vsel_def", ADDR_VSEL, 8'h55);
      chk("vsel_pin2", 8'h55, vsel);
      wsys(1'b1, 60, f, n);
      wr(ADDR_CTRL, 8'h00);
   endtask

   task automatic t_uv;
      wr(ADDR_VSEL, 8'h33);
      uv <= 1'b1;
      repeat (LVQ_C) @(posedge clk);
      uv <= 1'b0;
      wsys(1'b0, 20, f, n);
      chk("dip_ignored", 0, f);
      uv <= 1'b1;
      wsys(1'b0, LVQ_C + 6, f, n);
      chk("uv_reset", 1, f);
      uv <= 1'b0;
      rdc("low_voltage_reset_flag_set", ADDR_CTRL, 8'h04);
      rdc("vsel_kept", ADDR_VSEL, 8'h33);
      wsys(1'b1, 60, f, n);
      pd <= 1'b1;
      uv <= 1'b1;
      wsys(1'b0, 30, f, n);
      chk("uv_sleep", 0, f);
      uv <= 1'b0;
      pd <= 1'b0;
      wr(ADDR_CTRL, 8'h00);
      rdc("low_voltage_reset_flag_clr", ADDR_CTRL, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_por();
      t_ctrl();
      t_kick();
      t_timeout();
      t_sleep();
      t_badkey();
      t_vsel();
      t_uv();
      give_verdict();
   end

   // hang guard, well beyond the longest expected run
   initial begin
      #(40 * 60000);
      bad_count++;
      give_verdict();
   end
endmodule // tb_wdr_top
